//--- logic/cor_pkg.sv
// package of register map, field layouts and reset values for the clock output routing block
package cor_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [9:0] COR_IDX_TRIM_RB = 10'h074;
	localparam logic [9:0] COR_IDX_LOADCAP = 10'h077;
	localparam logic [9:0] COR_IDX_SRC_SEL = 10'h07C;
	localparam logic [9:0] COR_IDX_DIV_CTL = 10'h07D;
	localparam logic [9:0] COR_IDX_OUT_EN = 10'h07E;

	// field layout of the source select register
	typedef struct packed {
		logic [8:0] rsv_hi;
		logic [1:0] clk_pin_b_source;
		logic [1:0] clk_pin_c_source;
		logic [1:0] rsv_lo;
		logic clk_pin_e_source;
	} cor_src_reg_t;

	// field layout of the divider control register
	typedef struct packed {
		logic [7:0] rsv_hi;
		logic pll_b_post_divider;
		logic pll_c_post_divider;
		logic rsv_mid;
		logic [1:0] master_clock_divider;
		logic clk_pin_c_divide;
		logic clk_pin_b_divide;
		logic clk_pin_e_divide;
	} cor_div_reg_t;

	// field layout of the output enable register
	typedef struct packed {
		logic [10:0] rsv_hi;
		logic rsv_4;
		logic clk_pin_b_drive_enable;
		logic clk_pin_c_drive_enable;
		logic rsv_1;
		logic clk_pin_e_drive_enable;
	} cor_oe_reg_t;

	// field layout of the load capacitance offset register
	typedef struct packed {
		logic [7:0] rsv_hi;
		logic [3:0] out_crystal_cap_offset;
		logic [3:0] in_crystal_cap_offset;
	} cor_cap_reg_t;

	// source select codes
	localparam logic [1:0] COR_SRC_PLL = 2'h0;
	localparam logic [1:0] COR_SRC_GPIO = 2'h1;
	localparam logic [1:0] COR_SRC_ALT = 2'h2;
	localparam logic [1:0] COR_SRC_RSV = 2'h3;

	// values after reset (override low, forced fields at their locked values)
	localparam logic [3:0] COR_RST_CAP = 4'h0;
	localparam logic [1:0] COR_RST_B_SRC = 2'h0;
	localparam logic [1:0] COR_RST_C_SRC = 2'h2;
	localparam logic COR_RST_E_SRC = 1'b1;
	localparam logic COR_RST_B_POST = 1'b0;
	localparam logic COR_RST_C_POST = 1'b1;
	localparam logic [1:0] COR_RST_MDIV = 2'h1;
	localparam logic COR_RST_C_DIV = 1'b0;
	localparam logic COR_RST_B_DIV = 1'b1;
	localparam logic COR_RST_E_DIV = 1'b1;
	localparam logic COR_RST_OE = 1'b1;
	localparam logic COR_RSV_OE = 1'b1;

	// defaults loaded when the override goes high
	localparam logic [1:0] COR_OVR_C_SRC = 2'h0;
	localparam logic COR_OVR_E_SRC = 1'b0;
	localparam logic COR_OVR_DIV = 1'b0;

	// divider shift that parks an output low
	localparam logic [1:0] COR_SHIFT_OFF = 2'h3;

	// synchroniser lane positions
	localparam int COR_SY_PLL_B = 0;
	localparam int COR_SY_PLL_C = 1;
	localparam int COR_SY_FLL = 2;
	localparam int COR_SY_OSC = 3;
	localparam int COR_SY_GP_B = 4;
	localparam int COR_SY_GP_C = 5;
	localparam int COR_SY_STRAP = 6;
	localparam int COR_SY_OVR = 7;
	localparam int COR_SY_W = 8;

endpackage : cor_pkg

//--- logic/cor_div_if.sv
// interface between the routing control and one clock divider
`timescale 1ns/1ps
interface cor_div_if;
	logic src;
	logic [1:0] shift;
	logic out;
	modport ctl (output src, output shift, input out);
	modport div (input src, input shift, output out);
endinterface : cor_div_if

//--- logic/cor_sync.sv
// two-flop synchroniser bank for pins and foreign clocks
`timescale 1ns/1ps
module cor_sync #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} cor_sync_st_t;

	cor_sync_st_t s;
	cor_sync_st_t next_s;

	// stage1 is only ever read by stage2
	always_comb begin
		next_s = s;
		next_s.stage1 = din;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.stage2;
endmodule : cor_sync

//--- logic/cor_div.sv
// power-of-two divider for a sampled clock level
`timescale 1ns/1ps
module cor_div (
	input wire logic mclk,
	input wire logic reset_n,
	cor_div_if.div port
);
	typedef struct packed {
		logic prev;
		logic [1:0] cnt;
		logic out;
	} cor_div_st_t;

	cor_div_st_t s;
	cor_div_st_t next_s;

	// count rising edges; shift 0 passes through, 1 halves, 2 quarters, 3 parks low
	always_comb begin
		next_s = s;
		next_s.prev = port.src;
		if (port.src && !s.prev) begin
			next_s.cnt = s.cnt + 2'h1;
		end
		unique case (port.shift)
			2'h0: next_s.out = port.src;
			2'h1: next_s.out = next_s.cnt[0];
			2'h2: next_s.out = next_s.cnt[1];
			2'h3: next_s.out = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign port.out = s.out;
endmodule : cor_div

//--- logic/clock_output_routing.sv
// clock output routing: apb registers, override locking, source muxing and output dividers
// Operation
// R01: read-only trimmed output crystal capacitance code
// R02: trim readback gated by security key
// R03: output crystal load offset, bits 7:4
// R04: input crystal load offset, bits 3:0
// R05: pin b source select, bits 6:5
// R06: pin c source select, bits 4:3
// R07: override low locks pin c source
// R08: pin e source: oscillator or loop
// R09: override low: strap decides pin e source
// R10: override high: pin e source writable, default 0
// R11: pll b post divide 2 or 4
// R12: pll c post divide 2 or 4
// R13: master clock divide 1, 2, 4
// R14: pin c optional divide by two
// R15: pin b divide locked when override low
// R16: pin e divide locked when override low
// R17: pin drive enables, default on
// R18: software keeps reserved enable bits at one
// R19: re-evaluate forced fields on override/strap change
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module clock_output_routing (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] out_crystal_trim_value,
	input wire logic key_open,
	input wire logic clock_override,
	input wire logic strap_pin,
	input wire logic pll_b,
	input wire logic pll_c,
	input wire logic fll_clk,
	input wire logic osc_clk,
	input wire logic gp_pin_b,
	input wire logic gp_pin_c,
	input wire logic master_from_osc,
	output logic master_clock,
	output logic clk_pin_b,
	output logic clk_pin_b_oe,
	output logic clk_pin_c,
	output logic clk_pin_c_oe,
	output logic clk_pin_e,
	output logic clk_pin_e_oe,
	output logic [3:0] out_crystal_cap_offset,
	output logic [3:0] in_crystal_cap_offset
);
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [15:0] prdata;
		logic [3:0] out_cap;
		logic [3:0] in_cap;
		logic [1:0] b_src;
		logic [1:0] c_src;
		logic e_src;
		logic b_post;
		logic c_post;
		logic [1:0] mdiv;
		logic c_div;
		logic b_div;
		logic e_div;
		logic b_oe;
		logic c_oe;
		logic e_oe;
		logic [1:0] mode;
	} cor_state_t;

	localparam cor_state_t COR_RST_STATE = '{
		pready: 1'b0, pslverr: 1'b0, prdata: 16'h0000,
		out_cap: cor_pkg::COR_RST_CAP, in_cap: cor_pkg::COR_RST_CAP,
		b_src: cor_pkg::COR_RST_B_SRC, c_src: cor_pkg::COR_RST_C_SRC, e_src: cor_pkg::COR_RST_E_SRC,
		b_post: cor_pkg::COR_RST_B_POST, c_post: cor_pkg::COR_RST_C_POST, mdiv: cor_pkg::COR_RST_MDIV,
		c_div: cor_pkg::COR_RST_C_DIV, b_div: cor_pkg::COR_RST_B_DIV, e_div: cor_pkg::COR_RST_E_DIV,
		b_oe: cor_pkg::COR_RST_OE, c_oe: cor_pkg::COR_RST_OE, e_oe: cor_pkg::COR_RST_OE,
		mode: 2'h0};

	cor_state_t s;
	cor_state_t next_s;
	logic [cor_pkg::COR_SY_W-1:0] sy;
	logic ovr;
	logic strap;
	logic acc_first;
	logic wr_take;
	cor_pkg::cor_src_reg_t wr_src;
	cor_pkg::cor_div_reg_t wr_div;
	cor_pkg::cor_oe_reg_t wr_oe;
	cor_pkg::cor_cap_reg_t wr_cap;

	////////////////////////////////////////////////////////////////////////
	// mode and gp pins and foreign clocks pass two flops before any logic reads them; key_open, trim value and master_from_osc are read directly
	cor_sync #(.W(cor_pkg::COR_SY_W)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.din({clock_override, strap_pin, gp_pin_c, gp_pin_b, osc_clk, fll_clk, pll_c, pll_b}),
		.dout(sy)
	);

	assign ovr = sy[cor_pkg::COR_SY_OVR];
	assign strap = sy[cor_pkg::COR_SY_STRAP];
	assign acc_first = psel && penable && !s.pready;
	assign wr_take = psel && penable && s.pready && pwrite;
	assign wr_src = pwdata[15:0];
	assign wr_div = pwdata[15:0];
	assign wr_oe = pwdata[15:0];
	assign wr_cap = pwdata[15:0];

	////////////////////////////////////////////////////////////////////////
	// register access, then override locking, which wins over a write in the same cycle
	always_comb begin
		next_s = s;
		next_s.pready = acc_first;
		if (acc_first) begin
			next_s.pslverr = 1'b0;
			unique case (paddr)
				{cor_pkg::COR_IDX_TRIM_RB, 2'h0}: begin
					// trim code only shown while the key is open [R01] [R02]
					next_s.prdata = key_open ? {11'h000, out_crystal_trim_value} : 16'h0000;
				end
				{cor_pkg::COR_IDX_LOADCAP, 2'h0}: begin
					next_s.prdata = {8'h00, s.out_cap, s.in_cap};
				end
				{cor_pkg::COR_IDX_SRC_SEL, 2'h0}: begin
					next_s.prdata = {9'h000, s.b_src, s.c_src, 2'h0, s.e_src};
				end
				{cor_pkg::COR_IDX_DIV_CTL, 2'h0}: begin
					next_s.prdata = {8'h00, s.b_post, s.c_post, 1'b0, s.mdiv, s.c_div, s.b_div, s.e_div};
				end
				{cor_pkg::COR_IDX_OUT_EN, 2'h0}: begin
					// reserved enable bits always read back as one [R18]
					next_s.prdata = {11'h000, cor_pkg::COR_RSV_OE, s.b_oe, s.c_oe, cor_pkg::COR_RSV_OE, s.e_oe};
				end
				default: begin
					next_s.prdata = 16'h0000;
					next_s.pslverr = 1'b1;
				end
			endcase
		end else begin
			next_s.pslverr = 1'b0;
		end
		if (wr_take) begin
			unique case (paddr)
				{cor_pkg::COR_IDX_LOADCAP, 2'h0}: begin
					next_s.out_cap = wr_cap.out_crystal_cap_offset; // [R03]
					next_s.in_cap = wr_cap.in_crystal_cap_offset; // [R04]
				end
				{cor_pkg::COR_IDX_SRC_SEL, 2'h0}: begin
					next_s.b_src = wr_src.clk_pin_b_source; // [R05]
					if (s.mode[1]) begin
						next_s.c_src = wr_src.clk_pin_c_source; // [R07]
					end
					if (s.mode[1] || s.mode[0]) begin
						next_s.e_src = wr_src.clk_pin_e_source; // [R09] [R10]
					end
				end
				{cor_pkg::COR_IDX_DIV_CTL, 2'h0}: begin
					next_s.b_post = wr_div.pll_b_post_divider; // [R11]
					next_s.c_post = wr_div.pll_c_post_divider; // [R12]
					next_s.mdiv = wr_div.master_clock_divider; // [R13]
					next_s.c_div = wr_div.clk_pin_c_divide; // [R14]
					if (s.mode[1]) begin
						next_s.b_div = wr_div.clk_pin_b_divide; // [R15]
						next_s.e_div = wr_div.clk_pin_e_divide; // [R16]
					end
				end
				{cor_pkg::COR_IDX_OUT_EN, 2'h0}: begin
					next_s.b_oe = wr_oe.clk_pin_b_drive_enable; // [R17]
					next_s.c_oe = wr_oe.clk_pin_c_drive_enable; // [R17]
					next_s.e_oe = wr_oe.clk_pin_e_drive_enable; // [R17]
				end
				default: begin
					// trim readback and unmapped words ignore writes [R01]
				end
			endcase
		end
		// reload on override rise or any change while it is low; a strap change while it is high keeps software values [R19]
		next_s.mode = {ovr, strap};
		if ((ovr && !s.mode[1]) || (!ovr && {ovr, strap} != s.mode)) begin
			if (ovr) begin
				next_s.c_src = cor_pkg::COR_OVR_C_SRC; // [R07]
				next_s.e_src = cor_pkg::COR_OVR_E_SRC; // [R10]
				next_s.b_div = cor_pkg::COR_OVR_DIV; // [R15]
				next_s.e_div = cor_pkg::COR_OVR_DIV; // [R16]
			end else begin
				next_s.c_src = cor_pkg::COR_RST_C_SRC; // [R07]
				next_s.e_src = !strap; // [R09]
				next_s.b_div = cor_pkg::COR_RST_B_DIV; // [R15]
				next_s.e_div = cor_pkg::COR_RST_E_DIV; // [R16]
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s <= COR_RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dividers: 0 pll b post, 1 pll c post, 2 master, 3 pin b, 4 pin c, 5 pin e
	cor_div_if dif[6] ();

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_div
			cor_div u_div (
				.mclk(mclk),
				.reset_n(reset_n),
				.port(dif[gi])
			);
		end
	endgenerate

	// post dividers: shift 1 halves, shift 2 quarters [R11] [R12]
	assign dif[0].src = sy[cor_pkg::COR_SY_PLL_B];
	assign dif[0].shift = s.b_post ? 2'h2 : 2'h1; // [R11]
	assign dif[1].src = sy[cor_pkg::COR_SY_PLL_C];
	assign dif[1].shift = s.c_post ? 2'h2 : 2'h1; // [R12]
	// reserved code 11 parks the master clock low [R13]
	assign dif[2].src = master_from_osc ? sy[cor_pkg::COR_SY_OSC] : sy[cor_pkg::COR_SY_PLL_C];
	assign dif[2].shift = s.mdiv; // [R13]

	// pin b source mux; the reserved code parks the pin low [R05]
	always_comb begin
		unique case (s.b_src)
			cor_pkg::COR_SRC_PLL: dif[3].src = dif[0].out;
			cor_pkg::COR_SRC_GPIO: dif[3].src = sy[cor_pkg::COR_SY_GP_B];
			cor_pkg::COR_SRC_ALT: dif[3].src = sy[cor_pkg::COR_SY_OSC];
			cor_pkg::COR_SRC_RSV: dif[3].src = 1'b0;
		endcase
	end
	assign dif[3].shift = (s.b_src == cor_pkg::COR_SRC_RSV) ? cor_pkg::COR_SHIFT_OFF : {1'b0, s.b_div}; // [R05] [R15]

	// pin c source mux [R06]
	always_comb begin
		unique case (s.c_src)
			cor_pkg::COR_SRC_PLL: dif[4].src = dif[1].out;
			cor_pkg::COR_SRC_GPIO: dif[4].src = sy[cor_pkg::COR_SY_GP_C];
			cor_pkg::COR_SRC_ALT: dif[4].src = sy[cor_pkg::COR_SY_FLL];
			cor_pkg::COR_SRC_RSV: dif[4].src = 1'b0;
		endcase
	end
	assign dif[4].shift = (s.c_src == cor_pkg::COR_SRC_RSV) ? cor_pkg::COR_SHIFT_OFF : {1'b0, s.c_div}; // [R06] [R14]

	// pin e: loop when set, oscillator when clear [R08]
	assign dif[5].src = s.e_src ? sy[cor_pkg::COR_SY_FLL] : sy[cor_pkg::COR_SY_OSC];
	assign dif[5].shift = {1'b0, s.e_div}; // [R16]

	////////////////////////////////////////////////////////////////////////
	// every output is a flop of this module or of a divider
	assign prdata = {16'h0000, s.prdata};
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign master_clock = dif[2].out;
	assign clk_pin_b = dif[3].out;
	assign clk_pin_c = dif[4].out;
	assign clk_pin_e = dif[5].out;
	assign clk_pin_b_oe = s.b_oe;
	assign clk_pin_c_oe = s.c_oe;
	assign clk_pin_e_oe = s.e_oe;
	assign out_crystal_cap_offset = s.out_cap;
	assign in_crystal_cap_offset = s.in_cap;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_rd_first(logic [9:0] idx);
		psel && penable && !pready && !pwrite && paddr == {idx, 2'h0};
	endsequence

	sequence s_wr_take(logic [9:0] idx);
		psel && penable && pready && pwrite && paddr == {idx, 2'h0};
	endsequence

	property p_trim_open;
		(s_rd_first(cor_pkg::COR_IDX_TRIM_RB) ##0 key_open) |=> pready && prdata == {27'h0, $past(out_crystal_trim_value)};
	endproperty
	a_trim_open: assert property (p_trim_open) else $error("trim readback wrong"); // [R01]

	property p_trim_locked;
		(s_rd_first(cor_pkg::COR_IDX_TRIM_RB) ##0 !key_open) |=> pready && prdata == 32'h0;
	endproperty
	a_trim_locked: assert property (p_trim_locked) else $error("trim visible without key"); // [R02]

	property p_cap_wr;
		s_wr_take(cor_pkg::COR_IDX_LOADCAP) |=> {out_crystal_cap_offset, in_crystal_cap_offset} == $past(pwdata[7:0]);
	endproperty
	a_cap_wr: assert property (p_cap_wr) else $error("load offset not taken"); // [R03]

	property p_oe_wr;
		s_wr_take(cor_pkg::COR_IDX_OUT_EN) |=> clk_pin_b_oe == $past(pwdata[3]) && clk_pin_c_oe == $past(pwdata[2]);
	endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("drive enable not taken"); // [R17]

	property p_c_lock;
		!s.mode[1] |-> s.c_src == 2'h2 && s.b_div && s.e_div;
	endproperty
	a_c_lock: assert property (p_c_lock) else $error("locked field moved"); // [R07]

	property p_e_strap;
		s.mode == 2'h0 |-> s.e_src;
	endproperty
	a_e_strap: assert property (p_e_strap) else $error("pin e source not forced"); // [R09]

	property p_ovr_rise;
		$rose(ovr) |=> !s.e_src && s.c_src == 2'h0 && !s.b_div;
	endproperty
	a_ovr_rise: assert property (p_ovr_rise) else $error("override defaults not loaded"); // [R10]

	property p_b_rsv;
		(s.b_src == 2'h3) [*3] |-> !clk_pin_b;
	endproperty
	a_b_rsv: assert property (p_b_rsv) else $error("reserved pin b source drives"); // [R05]

	property p_mdiv_rsv;
		(s.mdiv == 2'h3) [*3] |-> !master_clock;
	endproperty
	a_mdiv_rsv: assert property (p_mdiv_rsv) else $error("reserved master divide drives"); // [R13]

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle"); // bus handshake
endmodule : clock_output_routing

//--- verif/clock_output_routing_tb.sv
// self-checking testbench for the clock output routing block
`timescale 1ns/1ps
module clock_output_routing_tb;
	logic mclk;
	logic reset_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] trim;
	logic key_open;
	logic clock_override;
	logic strap_pin;
	logic master_from_osc;
	logic master_clock;
	logic clk_pin_b;
	logic clk_pin_b_oe;
	logic clk_pin_c;
	logic clk_pin_c_oe;
	logic clk_pin_e;
	logic clk_pin_e_oe;
	logic [3:0] out_crystal_cap_offset;
	logic [3:0] in_crystal_cap_offset;
	logic [4:0] src_cnt = 5'h00;
	logic [31:0] seed = 32'h000084C1;
	logic [15:0] mir [5];
	int err_count = 0;
	int tests_run = 0;

	// sources are slow square waves so the two-flop sampling sees every edge
	clock_output_routing i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.out_crystal_trim_value(trim), .key_open(key_open), .clock_override(clock_override),
		.strap_pin(strap_pin), .pll_b(src_cnt[1]), .pll_c(src_cnt[1]), .fll_clk(src_cnt[3]),
		.osc_clk(src_cnt[2]), .gp_pin_b(src_cnt[4]), .gp_pin_c(src_cnt[3]), .master_from_osc(master_from_osc),
		.master_clock(master_clock), .clk_pin_b(clk_pin_b), .clk_pin_b_oe(clk_pin_b_oe), .clk_pin_c(clk_pin_c),
		.clk_pin_c_oe(clk_pin_c_oe), .clk_pin_e(clk_pin_e), .clk_pin_e_oe(clk_pin_e_oe),
		.out_crystal_cap_offset(out_crystal_cap_offset), .in_crystal_cap_offset(in_crystal_cap_offset));

	// clock and source counter
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		src_cnt <= src_cnt + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [11:0] adr(input int i);
		case (i)
			0: adr = {cor_pkg::COR_IDX_TRIM_RB, 2'h0};
			1: adr = {cor_pkg::COR_IDX_LOADCAP, 2'h0};
			2: adr = {cor_pkg::COR_IDX_SRC_SEL, 2'h0};
			3: adr = {cor_pkg::COR_IDX_DIV_CTL, 2'h0};
			default: adr = {cor_pkg::COR_IDX_OUT_EN, 2'h0};
		endcase
	endfunction : adr

	// expected register contents after a write, given the current mode pins
	function automatic logic [15:0] wr_val(input int i, input logic [15:0] d);
		logic [15:0] v;
		v = 16'h0000;
		case (i)
			1: v = d & 16'h00FF;
			2: begin
				v = d & 16'h0079;
				if (!clock_override) v[4:3] = 2'h2;
				if (!clock_override && !strap_pin) v[0] = 1'b1;
			end
			3: begin
				v = d & 16'h00DF;
				if (!clock_override) v[1:0] = 2'h3;
			end
			4: v = (d & 16'h000D) | 16'h0012;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : wr_val

	function automatic logic pick(input int sel);
		case (sel)
			0: pick = master_clock;
			1: pick = clk_pin_b;
			2: pick = clk_pin_c;
			default: pick = clk_pin_e;
		endcase
	endfunction : pick

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// apb master: request held until pready is seen high at a rising edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			err_count++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic wreg(input int i, input logic [15:0] d);
		logic [31:0] rd;
		logic er;
		if (i == 4) d = d | 16'h0012;
		bus(1'b1, adr(i), {16'h0000, d}, rd, er);
		check({31'h0, er}, 32'h0, "write error");
		if (i != 0) mir[i] = wr_val(i, d);
	endtask : wreg

	// reads every register back and compares it and the port copies with the mirror
	task automatic check_all;
		logic [31:0] r;
		logic [31:0] rd;
		logic er;
		r = xs();
		trim <= r[4:0];
		key_open <= r[8];
		bus(1'b0, adr(0), 32'h0, rd, er);
		check(rd, r[8] ? {27'h0, r[4:0]} : 32'h0, "trim readback");
		bus(1'b0, adr(1), 32'h0, rd, er);
		check(rd, {16'h0000, mir[1]}, "offset register");
		bus(1'b0, adr(2), 32'h0, rd, er);
		check(rd, {16'h0000, mir[2]}, "source register");
		bus(1'b0, adr(3), 32'h0, rd, er);
		check(rd, {16'h0000, mir[3]}, "divider register");
		bus(1'b0, adr(4), 32'h0, rd, er);
		check(rd, {16'h0000, mir[4]}, "enable register");
		check({24'h0, out_crystal_cap_offset, in_crystal_cap_offset}, {24'h0, mir[1][7:0]}, "cap ports");
		check({29'h0, clk_pin_b_oe, clk_pin_c_oe, clk_pin_e_oe}, {29'h0, mir[4][3], mir[4][2], mir[4][0]}, "oe");
	endtask : check_all

	task automatic rand_writes(input int n);
		logic [31:0] r;
		logic [31:0] rd;
		logic er;
		repeat (n) begin
			r = xs();
			if (r[3:0] == 4'h0) begin
				bus(1'b0, r[5] ? 12'h1D4 : 12'h000, r, rd, er);
				check({31'h0, er}, 32'h1, "unmapped error");
				check(rd, 32'h0, "unmapped data");
			end else begin
				wreg(int'(r[7:4]) % 5, r[31:16]);
			end
		end
		check_all();
	endtask : rand_writes

	// mode pin change: forced or default values are reloaded once synchronised
	task automatic set_mode(input logic o, input logic s);
		@(posedge mclk);
		clock_override <= o;
		strap_pin <= s;
		repeat (8) @(posedge mclk);
		if (o) begin
			mir[2][4:3] = 2'h0;
			mir[2][0] = 1'b0;
			mir[3][1:0] = 2'h0;
		end else begin
			mir[2][4:3] = 2'h2;
			mir[3][1:0] = 2'h3;
			mir[2][0] = !s;
		end
		check_all();
	endtask : set_mode

	// counts output rises over 256 cycles; one rise of slack for phase
	task automatic rate(input int sel, input int exp);
		int n;
		logic prev;
		logic cur;
		n = 0;
		prev = 1'b0;
		repeat (24) @(posedge mclk);
		repeat (256) begin
			@(posedge mclk);
			cur = pick(sel);
			if (cur === 1'b1 && prev !== 1'b1) n++;
			prev = cur;
		end
		check(32'(n >= exp - 1 && n <= exp + 1), 32'h1, "clock rate");
	endtask : rate

	task automatic do_reset;
		reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		check({29'h0, clk_pin_b_oe, clk_pin_c_oe, clk_pin_e_oe}, 32'h7, "oe in reset");
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		mir[1] = 16'h0000;
		mir[2] = 16'h0011;
		mir[3] = 16'h004B;
		mir[4] = 16'h001F;
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		trim = 5'h00;
		key_open = 1'b0;
		clock_override = 1'b0;
		strap_pin = 1'b0;
		master_from_osc = 1'b1;
		do_reset();
		check_all();
		rate(1, 16);
		rate(2, 16);
		rate(3, 8);
		for (int i = 0; i < 4; i++) begin
			wreg(3, (mir[3] & 16'hFFE7) | 16'(i << 3));
			rate(0, (i == 3) ? 0 : (32 >> i));
		end
		master_from_osc <= 1'b0;
		wreg(3, mir[3] & 16'hFFE7);
		rate(0, 64);
		master_from_osc <= 1'b1;
		wreg(2, 16'h0000);
		wreg(3, 16'h0000);
		check_all();
		rand_writes(30);
		set_mode(1'b0, 1'b1);
		wreg(2, mir[2] | 16'h0001);
		check_all();
		rand_writes(20);
		set_mode(1'b0, 1'b0);
		set_mode(1'b1, 1'b0);
		wreg(2, 16'h0020);
		wreg(3, 16'h000C);
		wreg(4, 16'h001F);
		rate(1, 8);
		rate(2, 16);
		rate(3, 32);
		wreg(2, 16'h0060);
		rate(1, 0);
		wreg(4, 16'h0000);
		check_all();
		rand_writes(40);
		set_mode(1'b0, 1'b0);
		do_reset();
		check_all();
		report_and_stop();
	end
endmodule : clock_output_routing_tb
